/* File: design/tct_timer.sv */
// two-channel capture/compare timer with ahb-lite register slave
// assumes hclk at 40 mhz; pins arrive asynchronously and are synchronised
//
// What this block does
// (R1) halt bit resets set; counter holds while set, runs when cleared
// (R2) captures are suppressed while the halt bit is set
// (R3) clear bit zeroes counter and prescaler, self-clears, reads zero
// (R4) halt and clear together leave counter stopped at zero
// (R5) source field: bus clock divided by 1..64, or external clock pin
// (R6) high count read latches low byte until low byte read
// (R7) counter equal to wrap limit sets overflow flag, next tick to zero
// (R8) writing wrap high byte blocks overflow until wrap low written
// (R9) both wrap limit bytes reset to all ones
// (R10) event flag set on active capture edge or on compare match
// (R11) event flag clears by read-seen-set then write zero, event wins
// (R12) channel interrupt request only when flag and enable are set
// (R13) buffered mode ignores channel 1 control, frees channel 1 pin
// (R14) nonzero edge field: mode-a selects capture or compare
// (R15) zero edge field: mode-a presets output level, one gives low
// (R16) zero edge field disconnects channel from its pin
// (R17) capture edges: one rising, two falling, three either
// (R18) compare action: one toggle, two clear, three set; zero flag only
// (R19) toggle-on-wrap toggles pin at overflow, overflow beats compare
// (R20) full duty bit with toggle-on-wrap forces full duty next period
// (R21) value high byte read blocks captures until low byte read
// (R22) value high byte write blocks compares until low byte written
// (R23) overflow flag clears like event flags; enable gates its request
// (R24) buffered mode links channels, channel 0 values active first
// (R25) debug halt stops counter and suppresses captures
// (R26) buffered mode alternates active value register each period
//
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module tct_timer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic debug_halt,
    input wire logic ext_timer_clock_pin,
    input wire logic [1:0] chan_pin_in,
    output logic [1:0] chan_pin_out,
    output logic [1:0] chan_pin_oe_n,
    output logic overflow_irq,
    output logic [1:0] chan_irq
);
    import tct_pkg::*;

    // ------------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------------
    logic [2:0] sync1, sync2, sync_d;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            sync_d <= 3'h0;
        end else begin
            sync1 <= {ext_timer_clock_pin, chan_pin_in};
            sync2 <= sync1;
            sync_d <= sync2;
        end
    end

    // ------------------------------------------------------------------
    // ahb-lite slave: registered data phase, no wait states
    // ------------------------------------------------------------------
    tct_bus_state_type bstate;
    logic [7:0] baddr;
    logic take;
    logic rd_ev, wr_ev;
    logic [7:0] wbyte;
    assign take = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign rd_ev = (bstate == ST_READ);
    assign wr_ev = (bstate == ST_WRITE);
    assign wbyte = hwdata[7:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bstate <= ST_IDLE;
            baddr <= 8'h00;
        end else begin
            if (take) begin
                bstate <= hwrite ? ST_WRITE : ST_READ;
                baddr <= haddr;
            end else begin
                bstate <= ST_IDLE;
            end
        end
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    logic halt, ovf_ie, ovf_flag, ovf_armed, wrap_hold;
    logic [2:0] src_sel;
    logic [15:0] wrap_lim, count, prescale;
    logic [7:0] wrap_hi_buf, low_latch;
    logic low_latched;
    tct_chan_ctrl_type cc [2];
    logic [15:0] cval [2];
    logic [7:0] cval_hi_buf [2];
    logic [1:0] cap_block, cmp_block, flag_armed, pin_level;
    logic clr_req, tick, wrap_hit, ovf_event;
    logic run_stop, buf_active_sel;

    assign clr_req = wr_ev && baddr == ADDR_TIMER_CTRL && wbyte[TC_CLR_BIT];
    assign run_stop = halt || debug_halt;  // [R1] [R25]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            halt <= 1'b1;  // [R1]
            ovf_ie <= 1'b0;
            src_sel <= 3'h0;
        end else if (wr_ev && baddr == ADDR_TIMER_CTRL) begin
            halt <= wbyte[TC_HALT_BIT];  // [R1] [R4]
            ovf_ie <= wbyte[TC_OVIE_BIT];
            src_sel <= wbyte[2:0];
        end
    end

    // ------------------------------------------------------------------
    // prescaler and counter
    // ------------------------------------------------------------------
    logic ext_rise;
    assign ext_rise = sync2[2] && !sync_d[2];
    always_comb begin
        if (src_sel == SRC_EXTERNAL) begin
            tick = ext_rise;  // [R5]
        end else begin
            // divide by 2^n: tick when the low n bits are all ones, just before they wrap
            tick = ((prescale & ((16'h1 << src_sel) - 16'h1)) ==
                    ((16'h1 << src_sel) - 16'h1));  // [R5]
        end
    end

    assign wrap_hit = tick && !run_stop && (count == wrap_lim);
    assign ovf_event = wrap_hit && !wrap_hold;  // [R8]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prescale <= 16'h0;
            count <= 16'h0;
        end else if (clr_req) begin
            prescale <= 16'h0;  // [R3] [R4]
            count <= 16'h0;
        end else if (!run_stop) begin
            prescale <= prescale + 16'h1;
            if (tick) begin
                count <= wrap_hit ? 16'h0 : count + 16'h1;  // [R7]
            end
        end
    end

    // ------------------------------------------------------------------
    // wrap limit with high-byte buffer
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wrap_lim <= WRAP_RESET;  // [R9]
            wrap_hi_buf <= WRAP_RESET[15:8];
            wrap_hold <= 1'b0;
        end else if (wr_ev && baddr == ADDR_WRAP_HIGH) begin
            wrap_hi_buf <= wbyte;
            wrap_hold <= 1'b1;  // [R8]
        end else if (wr_ev && baddr == ADDR_WRAP_LOW) begin
            wrap_lim <= {wrap_hi_buf, wbyte};
            wrap_hold <= 1'b0;  // [R8]
        end
    end

    // ------------------------------------------------------------------
    // overflow flag: read-armed clear, new event wins
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovf_flag <= 1'b0;
            ovf_armed <= 1'b0;
        end else if (ovf_event) begin
            ovf_flag <= 1'b1;  // [R7] [R23]
            ovf_armed <= 1'b0;
        end else if (rd_ev && baddr == ADDR_TIMER_CTRL && ovf_flag) begin
            ovf_armed <= 1'b1;
        end else if (wr_ev && baddr == ADDR_TIMER_CTRL) begin
            if (ovf_armed && !wbyte[TC_OVF_BIT]) begin
                ovf_flag <= 1'b0;  // [R23]
            end
            ovf_armed <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // count read latch
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_latch <= 8'h0;
            low_latched <= 1'b0;
        end else if (clr_req) begin
            low_latch <= 8'h0;  // [R6]
            low_latched <= 1'b0;
        end else if (take && !hwrite && haddr == ADDR_COUNT_HIGH &&
                     !low_latched) begin
            // latched at the edge that samples the high byte: pair coherent
            low_latch <= count[7:0];  // [R6]
            low_latched <= 1'b1;
        end else if (take && !hwrite && haddr == ADDR_COUNT_LOW) begin
            low_latched <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // buffered-mode active register toggles at each period end
    // ------------------------------------------------------------------
    logic buffered;
    assign buffered = cc[0].buf_sel;  // [R13] [R24]
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            buf_active_sel <= 1'b0;
        end else if (!buffered) begin
            buf_active_sel <= 1'b0;  // [R24]
        end else if (wrap_hit) begin
            buf_active_sel <= !buf_active_sel;  // [R26]
        end
    end

    // ------------------------------------------------------------------
    // channels
    // ------------------------------------------------------------------
    logic [1:0] cap_ev, cmp_ev, ch_flag_set, ch_enabled, is_cap;
    logic [1:0] max_now;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_chan
            localparam logic [7:0] A_CTRL =
                g ? ADDR_CHAN1_CTRL : ADDR_CHAN0_CTRL;
            localparam logic [7:0] A_HIGH =
                g ? ADDR_CHAN1_HIGH : ADDR_CHAN0_HIGH;
            localparam logic [7:0] A_LOW =
                g ? ADDR_CHAN1_LOW : ADDR_CHAN0_LOW;
            logic rise, fall, is_buf, cmp_match;
            logic [15:0] cmp_val;
            tct_chan_ctrl_type eff;
            assign eff = cc[g];
            assign is_buf = (g == 0) && buffered;
            // channel 1 control is ignored in buffered mode; its value register serves channel 0
            assign ch_enabled[g] = !(g == 1 && buffered) &&
                                   cc[g].edge_level != EL_OFF;  // [R13] [R16]
            assign is_cap[g] = ch_enabled[g] && !is_buf &&
                               !cc[g].mode_a;  // [R14]
            assign rise = sync2[g] && !sync_d[g];
            assign fall = !sync2[g] && sync_d[g];
            assign cap_ev[g] = is_cap[g] && !run_stop && !cap_block[g] &&
                ((cc[g].edge_level[0] && rise) ||
                 (cc[g].edge_level[1] && fall));  // [R2] [R17] [R21] [R25]
            assign cmp_val = is_buf ? cval[buf_active_sel] : cval[g];
            assign cmp_match = tick && !run_stop && count == cmp_val;
            assign cmp_ev[g] = !is_cap[g] && !cmp_block[g] && cmp_match &&
                ((cc[g].mode_a && !(g == 1 && buffered)) || is_buf);  // [R10]
            assign ch_flag_set[g] = cap_ev[g] || cmp_ev[g];  // [R10]

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cc[g] <= '0;
                    flag_armed[g] <= 1'b0;
                end else begin
                    if (wr_ev && baddr == A_CTRL) begin
                        cc[g].irq_en <= wbyte[CC_IE_BIT];
                        cc[g].buf_sel <= g == 0 && wbyte[CC_BUF_BIT];  // [R13]
                        cc[g].mode_a <= wbyte[CC_MODEA_BIT];
                        cc[g].edge_level <= wbyte[CC_ELHI_BIT:CC_ELLO_BIT];
                        cc[g].tov <= wbyte[CC_TOV_BIT];
                        cc[g].full_duty <= wbyte[CC_MAX_BIT];
                    end
                    if (ch_flag_set[g]) begin
                        cc[g].flag <= 1'b1;  // [R10] [R11]
                        flag_armed[g] <= 1'b0;
                    end else if (rd_ev && baddr == A_CTRL && cc[g].flag) begin
                        flag_armed[g] <= 1'b1;
                    end else if (wr_ev && baddr == A_CTRL) begin
                        if (flag_armed[g] && !wbyte[CC_FLAG_BIT]) begin
                            cc[g].flag <= 1'b0;  // [R11]
                        end
                        flag_armed[g] <= 1'b0;
                    end
                end
            end

            // value registers have no reset: contents start unknown
            always_ff @(posedge hclk) begin
                if (cap_ev[g]) begin
                    cval[g] <= count;
                end else if (wr_ev && baddr == A_HIGH) begin
                    cval_hi_buf[g] <= wbyte;
                end else if (wr_ev && baddr == A_LOW) begin
                    cval[g] <= {cval_hi_buf[g], wbyte};
                end
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cap_block[g] <= 1'b0;
                    cmp_block[g] <= 1'b0;
                end else begin
                    if (rd_ev && baddr == A_HIGH && is_cap[g]) begin
                        cap_block[g] <= 1'b1;  // [R21]
                    end else if (rd_ev && baddr == A_LOW) begin
                        cap_block[g] <= 1'b0;
                    end
                    if (wr_ev && baddr == A_HIGH) begin
                        cmp_block[g] <= 1'b1;  // [R22]
                    end else if (wr_ev && baddr == A_LOW) begin
                        cmp_block[g] <= 1'b0;
                    end
                end
            end

            // full duty latched at period start
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    max_now[g] <= 1'b0;
                end else if (wrap_hit) begin
                    max_now[g] <= eff.full_duty && eff.tov;  // [R20]
                end
            end

            // output level
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    pin_level[g] <= 1'b1;
                end else if (!ch_enabled[g]) begin
                    pin_level[g] <= !cc[g].mode_a;  // [R15]
                end else if (!is_cap[g]) begin
                    if (wrap_hit && cc[g].tov) begin
                        pin_level[g] <= !pin_level[g];  // [R19]
                    end else if (max_now[g]) begin
                        pin_level[g] <= 1'b1;  // [R20]
                    end else if (cmp_ev[g]) begin
                        unique case (cc[g].edge_level)  // [R18]
                            EL_TOGGLE: pin_level[g] <= !pin_level[g];
                            EL_CLEAR: pin_level[g] <= 1'b0;
                            EL_SET: pin_level[g] <= 1'b1;
                            default: pin_level[g] <= pin_level[g];
                        endcase
                    end
                end
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    chan_pin_out[g] <= 1'b0;
                    chan_pin_oe_n[g] <= 1'b1;
                    chan_irq[g] <= 1'b0;
                end else begin
                    chan_pin_out[g] <= pin_level[g];
                    chan_pin_oe_n[g] <= !ch_enabled[g] || is_cap[g];  // [R16]
                    chan_irq[g] <= cc[g].flag && cc[g].irq_en;  // [R12]
                end
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overflow_irq <= 1'b0;
        end else begin
            overflow_irq <= ovf_flag && ovf_ie;  // [R23]
        end
    end

    // ------------------------------------------------------------------
    // read mux, registered into hrdata at the data phase
    // ------------------------------------------------------------------
    logic [7:0] rmux;
    always_comb begin
        unique case (haddr)
            ADDR_TIMER_CTRL: rmux = {ovf_flag, ovf_ie, halt, 1'b0,
                                     1'b0, src_sel};  // [R3]
            ADDR_COUNT_HIGH: rmux = count[15:8];
            ADDR_COUNT_LOW: rmux = low_latched ? low_latch : count[7:0];
            ADDR_WRAP_HIGH: rmux = wrap_lim[15:8];
            ADDR_WRAP_LOW: rmux = wrap_lim[7:0];
            ADDR_CHAN0_CTRL: rmux = cc[0];
            ADDR_CHAN0_HIGH: rmux = cval[0][15:8];
            ADDR_CHAN0_LOW: rmux = cval[0][7:0];
            ADDR_CHAN1_CTRL: rmux = cc[1];
            ADDR_CHAN1_HIGH: rmux = cval[1][15:8];
            ADDR_CHAN1_LOW: rmux = cval[1][7:0];
            default: rmux = 8'h00;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (take && !hwrite) begin
            hrdata <= {24'h0, rmux};
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    chk_halt_freeze: assert property (@(posedge hclk) disable iff (!hresetn)
        (run_stop && !clr_req) |=> $stable(count))  // [R1]
        else $error("counter moved while halted");
    chk_clear_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        clr_req |=> count == 16'h0)  // [R3]
        else $error("clear did not zero counter");
    chk_halt_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        (clr_req && wbyte[TC_HALT_BIT]) |=> (count == 16'h0)[*2])  // [R4]
        else $error("halt plus clear not held at zero");
    chk_wrap_restart: assert property (@(posedge hclk) disable iff (!hresetn)
        (wrap_hit && !clr_req) |=> count == 16'h0)  // [R7]
        else $error("counter did not restart after wrap");
    chk_ovf_block: assert property (@(posedge hclk) disable iff (!hresetn)
        (wrap_hold && !ovf_flag) |=> !ovf_flag)  // [R8]
        else $error("overflow set while wrap write pending");
    chk_no_cap_halt: assert property (@(posedge hclk) disable iff (!hresetn)
        run_stop |-> cap_ev == 2'b00)  // [R2]
        else $error("capture while halted");
    chk_flag_wins: assert property (@(posedge hclk) disable iff (!hresetn)
        ch_flag_set[0] |=> cc[0].flag)  // [R11]
        else $error("event flag lost");
    chk_chan_irq: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 chan_irq[0] == $past(cc[0].flag && cc[0].irq_en))  // [R12]
        else $error("channel irq mismatch");
    chk_ovf_irq: assert property (@(posedge hclk) disable iff (!hresetn)
        (ovf_flag && ovf_ie) |=> overflow_irq)  // [R23]
        else $error("overflow irq missing");
    chk_buf_pin1: assert property (@(posedge hclk) disable iff (!hresetn)
        buffered |=> chan_pin_oe_n[1])  // [R13]
        else $error("channel 1 pin driven in buffered mode");
    cov_wrap: cover property (@(posedge hclk) disable iff (!hresetn)
        ovf_event);
    cov_capture: cover property (@(posedge hclk) disable iff (!hresetn)
        cap_ev[0]);
    cov_compare: cover property (@(posedge hclk) disable iff (!hresetn)
        cmp_ev[1]);
    cov_buffered: cover property (@(posedge hclk) disable iff (!hresetn)
        buffered && wrap_hit);
endmodule

/* File: inc/tct_pkg.sv */
// package for the two-channel capture/compare timer
// assumes a single 40 mhz bus clock domain and an ahb-lite register port
package tct_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses, one aligned word per register)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_TIMER_CTRL = 8'h00;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h04;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h08;
    localparam logic [7:0] ADDR_WRAP_HIGH = 8'h0c;
    localparam logic [7:0] ADDR_WRAP_LOW = 8'h10;
    localparam logic [7:0] ADDR_CHAN0_CTRL = 8'h14;
    localparam logic [7:0] ADDR_CHAN0_HIGH = 8'h18;
    localparam logic [7:0] ADDR_CHAN0_LOW = 8'h1c;
    localparam logic [7:0] ADDR_CHAN1_CTRL = 8'h20;
    localparam logic [7:0] ADDR_CHAN1_HIGH = 8'h24;
    localparam logic [7:0] ADDR_CHAN1_LOW = 8'h28;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int TC_OVF_BIT = 7;
    localparam int TC_OVIE_BIT = 6;
    localparam int TC_HALT_BIT = 5;
    localparam int TC_CLR_BIT = 4;
    localparam int CC_FLAG_BIT = 7;
    localparam int CC_IE_BIT = 6;
    localparam int CC_BUF_BIT = 5;
    localparam int CC_MODEA_BIT = 4;
    localparam int CC_ELHI_BIT = 3;
    localparam int CC_ELLO_BIT = 2;
    localparam int CC_TOV_BIT = 1;
    localparam int CC_MAX_BIT = 0;

    // ------------------------------------------------------------------
    // reset values and encodings
    // ------------------------------------------------------------------
    localparam logic [15:0] WRAP_RESET = 16'hffff;
    localparam logic [2:0] SRC_EXTERNAL = 3'h7;
    localparam logic [1:0] EL_OFF = 2'h0;
    localparam logic [1:0] EL_TOGGLE = 2'h1;
    localparam logic [1:0] EL_CLEAR = 2'h2;
    localparam logic [1:0] EL_SET = 2'h3;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic flag;
        logic irq_en;
        logic buf_sel;
        logic mode_a;
        logic [1:0] edge_level;
        logic tov;
        logic full_duty;
    } tct_chan_ctrl_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_WRITE = 3'b100
    } tct_bus_state_type;

endpackage

/* File: sim/tct_pins.sv */
// far-side model: signal sources on the two channel pins
// assumes the bench commands drive_lvl; timer drives while oe_n is low
`timescale 1ns/1ps
module tct_pins (
    input wire logic [1:0] drive_lvl,
    input wire logic [1:0] chan_pin_out,
    input wire logic [1:0] chan_pin_oe_n,
    output logic [1:0] chan_pin_in
);
    // the wire follows whoever drives it, so a driven pin reads back
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            chan_pin_in[i] = chan_pin_oe_n[i] ? drive_lvl[i] : chan_pin_out[i];
        end
    end
endmodule

/* File: sim/testbench.sv */
// self-checking bench for the capture/compare timer
// assumes tct_pkg and the pin model are compiled first
`timescale 1ns/1ps
module testbench;
    import tct_pkg::*;
    logic hclk, hresetn, hsel, hwrite, ovf_irq, dbg, ext_clk;
    logic [7:0] haddr, rd, held;
    logic [1:0] htrans, drive_lvl, pin_in, pin_out, pin_oe_n, chan_irq;
    logic [31:0] hwdata, hrdata;
    logic hreadyout, hresp;
    int fails, checks_done;
    typedef struct {logic wr; logic [7:0] a; logic [7:0] d;} tct_row_type;
    tct_row_type rows[11] = '{'{0, ADDR_TIMER_CTRL, 8'h20},
        '{0, ADDR_WRAP_HIGH, 8'hff}, '{0, ADDR_WRAP_LOW, 8'hff},
        '{1, ADDR_TIMER_CTRL, 8'h30}, '{0, ADDR_COUNT_HIGH, 8'h00},
        '{0, ADDR_COUNT_LOW, 8'h00}, '{0, ADDR_TIMER_CTRL, 8'h20},
        '{1, ADDR_WRAP_HIGH, 8'h00}, '{1, ADDR_WRAP_LOW, 8'h03},
        '{0, ADDR_WRAP_LOW, 8'h03}, '{0, 8'h3c, 8'h00}};
    tct_timer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .debug_halt(dbg),
        .ext_timer_clock_pin(ext_clk), .chan_pin_in(pin_in),
        .chan_pin_out(pin_out), .chan_pin_oe_n(pin_oe_n),
        .overflow_irq(ovf_irq), .chan_irq(chan_irq));
    tct_pins pins (.drive_lvl(drive_lvl), .chan_pin_out(pin_out),
        .chan_pin_oe_n(pin_oe_n), .chan_pin_in(pin_in));
    // ------------------------------------------------------------------
    // bus cycles, comparison and verdict
    // ------------------------------------------------------------------
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata[7:0];
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    initial begin
        repeat (5000) @(posedge hclk);
        fails++;
        print_verdict();
    end
    initial begin
        {hsel, hwrite, haddr, htrans, hwdata, drive_lvl, dbg, ext_clk} = '0;
        hresetn = 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (rows[i]) begin
            bus(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr) chk(rd, rows[i].d);
        end
        $display("register table done");
        bus(1, ADDR_TIMER_CTRL, 8'h00);
        repeat (20) @(posedge hclk);
        bus(1, ADDR_TIMER_CTRL, 8'h20);
        bus(0, ADDR_TIMER_CTRL, 8'h00);
        chk(rd, 8'ha0);
        bus(1, ADDR_TIMER_CTRL, 8'he0);
        // enable lands at the data-phase edge, the request one edge later
        repeat (2) @(posedge hclk);
        chk({7'h0, ovf_irq}, 8'h01);
        bus(0, ADDR_TIMER_CTRL, 8'h00);
        bus(1, ADDR_TIMER_CTRL, 8'h20);
        bus(0, ADDR_TIMER_CTRL, 8'h00);
        chk(rd, 8'h20);
        $display("overflow test done");
        // halted: a rising edge must not capture
        bus(1, ADDR_CHAN0_CTRL, 8'h44);
        drive_lvl <= 2'h1;
        repeat (6) @(posedge hclk);
        bus(0, ADDR_CHAN0_CTRL, 8'h00);
        chk(rd, 8'h44);
        drive_lvl <= 2'h0;
        bus(1, ADDR_TIMER_CTRL, 8'h00);
        repeat (6) @(posedge hclk);
        drive_lvl <= 2'h1;
        repeat (6) @(posedge hclk);
        bus(0, ADDR_CHAN0_CTRL, 8'h00);
        chk(rd, 8'hc4);
        chk({7'h0, chan_irq[0]}, 8'h01);
        $display("capture test done");
        // debug halt: count must not move across seven cycles
        dbg <= 1'b1;
        bus(0, ADDR_COUNT_LOW, 8'h00);
        held = rd;
        repeat (5) @(posedge hclk);
        bus(0, ADDR_COUNT_LOW, 8'h00);
        chk(rd, held);
        dbg <= 1'b0;
        // channel 1 clears its pin on compare at 2
        bus(1, ADDR_CHAN1_HIGH, 8'h00);
        bus(1, ADDR_CHAN1_LOW, 8'h02);
        bus(1, ADDR_CHAN1_CTRL, 8'h18);
        repeat (10) @(posedge hclk);
        chk({4'h0, chan_irq[1], hresp, pin_out[1], pin_oe_n[1]}, 8'h00);
        bus(0, ADDR_CHAN1_CTRL, 8'h00);
        chk(rd, 8'h98);
        bus(1, ADDR_CHAN0_CTRL, 8'h20);
        repeat (3) @(posedge hclk);
        chk({7'h0, pin_oe_n[1]}, 8'h01);
        // external clock: two rising edges give a count of two
        bus(1, ADDR_TIMER_CTRL, 8'h30);
        bus(1, ADDR_TIMER_CTRL, 8'h07);
        repeat (2) begin
            ext_clk <= 1'b1;
            repeat (4) @(posedge hclk);
            ext_clk <= 1'b0;
            repeat (4) @(posedge hclk);
        end
        bus(0, ADDR_COUNT_LOW, 8'h00);
        chk(rd, 8'h02);
        $display("pin and clock test done");
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(0, ADDR_TIMER_CTRL, 8'h00);
        chk(rd, 8'h20);
        bus(0, ADDR_WRAP_LOW, 8'h00);
        chk(rd, 8'hff);
        $display("reset test done");
        print_verdict();
    end
endmodule
